/* File: hdl/pwcc_consts.vh */
// Constants for the PWM cycle and comparator clear block.
// Assumes an 8-bit special function register port with byte addresses.
`ifndef PWCC_CONSTS_VH
`define PWCC_CONSTS_VH
`define PWCC_ADDR_PWM_CFG 8'hf7
`define PWCC_ADDR_CMP_CLR 8'h9c
`define PWCC_ADDR_CP_LOW 8'he9
`define PWCC_ADDR_CP_HIGH 8'hea
`define PWCC_ADDR_CH_STRIDE 8'h02
`define PWCC_PWM_CFG_RESET 8'h00
`define PWCC_CMP_CLR_RESET 8'h00
`define PWCC_CFG_RELOAD_BANK_SELECT_BIT 7
`define PWCC_CFG_IRQEN_BIT 6
`define PWCC_CFG_OVF_BIT 5
`define PWCC_CLR_POL_BIT 7
`define PWCC_CYCLE_LENGTH_SELECT_8 3'h0
`define PWCC_CYCLE_LENGTH_SELECT_9 3'h1
`define PWCC_CYCLE_LENGTH_SELECT_10 3'h2
`define PWCC_CYCLE_LENGTH_SELECT_11 3'h3
`define PWCC_NUM_CH 3
`endif

/* File: hdl/pwcc_reg_mem.v */
// Small word memory holding the per-channel compare and reload bytes.
// Assumes a single clock; one write port, one read port, read data registered.
`timescale 1ns/100ps
`default_nettype none
module pwcc_reg_mem (
  // Clock
  input wire clock_i,
  // Write port
  input wire we_i,
  input wire [3:0] waddr_i,
  input wire [7:0] wdata_i,
  // Read port
  input wire [3:0] raddr_i,
  output reg [7:0] rdata_o
);
  reg [7:0] mem_q [0:15];

  // Registered read keeps the data path off the decode chain
  always @(posedge clock_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule // pwcc_reg_mem
`default_nettype wire

/* File: hdl/pwcc_top.v */
// PWM cycle configuration and comparator clear control for a three-channel counter array.
// Assumes the counter, channel mode bits and comparator arrive as synchronous inputs.
//
// Behaviour
// - Select bit steers accesses: compare or reload
// - Reload values used only in 9-11 bit modes
// - Overflow flag interrupts only when enabled
// - Flag set on overflow of selected bit
// - Flag set by hardware/software, cleared by software
// - Cycle field: 000=8, 001=9, 010=10, 011=11 bits
// - Cycle length applies to non-16-bit PWM channels
// - Polarity picks falling or rising clear edge
// - Per-channel enables gate the comparator clear
// - Wide select bit picks 16-bit PWM
`timescale 1ns/100ps
`default_nettype none
`include "pwcc_consts.vh"
module pwcc_top (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Register port
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] sfr_rdata_o,
  // Counter array state
  input wire [15:0] main_counter_i,
  input wire [2:0] pwm_mode_i,
  input wire [2:0] wide_pwm_select_i,
  // Comparator
  input wire cmp_result_i,
  // Results
  output reg cycle_irq_o,
  output reg cycle_ovf_pulse_o,
  output reg [2:0] cmp_clear_o,
  output reg [2:0] reload_valid_o,
  output reg [10:0] cycle_mask_o,
  output reg [3:0] cycle_bits_o
);
  // Configuration fields
  reg reload_bank_select_q;
  reg cycle_ovf_irq_enable_q;
  reg cycle_ovf_flag_q;
  reg [2:0] cycle_length_select_q;
  reg cmp_clear_polarity_q;
  reg [2:0] cmp_clear_enable_q;
  reg [15:0] counter_prev_q;
  reg cmp_prev_q;
  reg rd_mem_q;
  reg [7:0] rd_reg_q;

  // Width of the active cycle in bits; 16-bit channels bypass this
  function [3:0] pwcc_cycle_bits;
    input [2:0] sel;
    begin
      case (sel)
        `PWCC_CYCLE_LENGTH_SELECT_8: pwcc_cycle_bits = 4'h8;
        `PWCC_CYCLE_LENGTH_SELECT_9: pwcc_cycle_bits = 4'h9;
        `PWCC_CYCLE_LENGTH_SELECT_10: pwcc_cycle_bits = 4'ha;
        `PWCC_CYCLE_LENGTH_SELECT_11: pwcc_cycle_bits = 4'hb;
        default: pwcc_cycle_bits = 4'h8; // Reserved codes fall back to 8 bits
      endcase
    end
  endfunction

  // Channel index for a compare byte address, 3 when not a compare address
  function [2:0] pwcc_channel;
    input [7:0] addr;
    reg [7:0] off;
    begin
      off = addr - `PWCC_ADDR_CP_LOW;
      if (off < 8'h06) begin
        pwcc_channel = off[3:1];
      end else begin
        pwcc_channel = 3'h3;
      end
    end
  endfunction

  wire [3:0] bits_w = pwcc_cycle_bits(cycle_length_select_q);
  wire [2:0] ch_w = pwcc_channel(sfr_addr_i);
  wire is_cp_w = (ch_w != 3'h3);
  wire cfg_wr_w = sfr_wr_i && (sfr_addr_i == `PWCC_ADDR_PWM_CFG);
  wire clr_wr_w = sfr_wr_i && (sfr_addr_i == `PWCC_ADDR_CMP_CLR);
  wire [7:0] ch_off_w = sfr_addr_i - `PWCC_ADDR_CP_LOW;
  // Bank bit picks compare or reload half of the memory
  wire [3:0] mem_addr_w = {reload_bank_select_q, ch_w[1:0], ch_off_w[0]};
  wire [7:0] mem_rdata_w;

  // Overflow of the selected bit: carry out of the low field toward zero
  reg ovf_evt_w;
  always @* begin
    ovf_evt_w = 1'b0;
    case (bits_w)
      4'h8: ovf_evt_w = (counter_prev_q[7:0] == 8'hff) && (main_counter_i[7:0] == 8'h00);
      4'h9: ovf_evt_w = (counter_prev_q[8:0] == 9'h1ff) && (main_counter_i[8:0] == 9'h000);
      4'ha: ovf_evt_w = (counter_prev_q[9:0] == 10'h3ff) && (main_counter_i[9:0] == 10'h000);
      4'hb: ovf_evt_w = (counter_prev_q[10:0] == 11'h7ff) && (main_counter_i[10:0] == 11'h000);
      default: ovf_evt_w = 1'b0;
    endcase
  end

  // Comparator edge in the chosen direction
  wire cmp_edge_w = cmp_clear_polarity_q ? (cmp_result_i && !cmp_prev_q) : (!cmp_result_i && cmp_prev_q);

  pwcc_reg_mem u_mem (
    .clock_i(clock_i),
    .we_i(sfr_wr_i && is_cp_w),
    .waddr_i(mem_addr_w),
    .wdata_i(sfr_wdata_i),
    .raddr_i(mem_addr_w),
    .rdata_o(mem_rdata_w)
  );

  // Bank select: one bit steers compare bytes to the reload half
  // Software must flip it back before touching live compare values
  always @(posedge clock_i) begin
    if (reset_i) begin
      reload_bank_select_q <= 1'b0;
    end else if (cfg_wr_w) begin
      reload_bank_select_q <= sfr_wdata_i[`PWCC_CFG_RELOAD_BANK_SELECT_BIT];
    end
  end

  // Interrupt enable for the cycle overflow flag
  always @(posedge clock_i) begin
    if (reset_i) begin
      cycle_ovf_irq_enable_q <= 1'b0;
    end else if (cfg_wr_w) begin
      cycle_ovf_irq_enable_q <= sfr_wdata_i[`PWCC_CFG_IRQEN_BIT];
    end
  end

  // Cycle length code; reserved bits 4:3 are dropped, not stored
  // Reserved codes are kept so software reads back what it wrote
  always @(posedge clock_i) begin
    if (reset_i) begin
      cycle_length_select_q <= 3'h0;
    end else if (cfg_wr_w) begin
      cycle_length_select_q <= sfr_wdata_i[2:0];
    end
  end

  // Cycle overflow flag: hardware only ever sets it; software writes bit 5 to set or clear it
  // A set on the same edge as a software clear wins, so no wrap is lost
  always @(posedge clock_i) begin
    if (reset_i) begin
      cycle_ovf_flag_q <= 1'b0;
    end else if (ovf_evt_w) begin
      cycle_ovf_flag_q <= 1'b1;
    end else if (cfg_wr_w) begin
      cycle_ovf_flag_q <= sfr_wdata_i[`PWCC_CFG_OVF_BIT];
    end
  end

  // Comparator clear polarity
  always @(posedge clock_i) begin
    if (reset_i) begin
      cmp_clear_polarity_q <= 1'b0;
    end else if (clr_wr_w) begin
      cmp_clear_polarity_q <= sfr_wdata_i[`PWCC_CLR_POL_BIT];
    end
  end

  // Per-channel clear enables; reserved bits 6:3 are dropped
  always @(posedge clock_i) begin
    if (reset_i) begin
      cmp_clear_enable_q <= 3'h0;
    end else if (clr_wr_w) begin
      cmp_clear_enable_q <= sfr_wdata_i[2:0];
    end
  end

  // Counter history for wrap detection
  // Follows the pin in reset too, so a counter parked at a wrap point gives no false event
  always @(posedge clock_i) begin
    counter_prev_q <= main_counter_i;
  end

  // Comparator history; tracking the pin in reset avoids a false edge after release
  always @(posedge clock_i) begin
    cmp_prev_q <= cmp_result_i;
  end

  // Channels in narrow PWM: PWM enabled and wide mode clear
  reg [2:0] narrow_w;
  integer ch_idx;
  always @* begin
    narrow_w = 3'h0;
    for (ch_idx = 0; ch_idx < `PWCC_NUM_CH; ch_idx = ch_idx + 1) begin
      narrow_w[ch_idx] = pwm_mode_i[ch_idx] && !wide_pwm_select_i[ch_idx];
    end
  end

  // Low-bit mask of the cycle, one bit per counted bit
  function [10:0] pwcc_cycle_mask;
    input [3:0] bits;
    begin
      pwcc_cycle_mask = 11'h7ff >> (4'hb - bits);
    end
  endfunction

  // Interrupt request: flag masked by its enable
  always @(posedge clock_i) begin
    if (reset_i) begin
      cycle_irq_o <= 1'b0;
    end else begin
      cycle_irq_o <= cycle_ovf_flag_q && cycle_ovf_irq_enable_q;
    end
  end

  // One pulse per wrap, whatever the flag already holds
  always @(posedge clock_i) begin
    if (reset_i) begin
      cycle_ovf_pulse_o <= 1'b0;
    end else begin
      cycle_ovf_pulse_o <= ovf_evt_w;
    end
  end

  // Clear pulse only on enabled channels
  always @(posedge clock_i) begin
    if (reset_i) begin
      cmp_clear_o <= 3'h0;
    end else begin
      cmp_clear_o <= cmp_edge_w ? cmp_clear_enable_q : 3'h0;
    end
  end

  // Reload only matters for narrow PWM longer than 8 bits
  // 16-bit channels never see it, whatever the length code says
  always @(posedge clock_i) begin
    if (reset_i) begin
      reload_valid_o <= 3'h0;
    end else begin
      reload_valid_o <= (bits_w != 4'h8) ? narrow_w : 3'h0;
    end
  end

  // Mask shared by every narrow channel
  always @(posedge clock_i) begin
    if (reset_i) begin
      cycle_mask_o <= 11'h0ff;
    end else begin
      cycle_mask_o <= pwcc_cycle_mask(bits_w);
    end
  end

  // Cycle width in bits, 8 to 11
  always @(posedge clock_i) begin
    if (reset_i) begin
      cycle_bits_o <= 4'h8;
    end else begin
      cycle_bits_o <= bits_w;
    end
  end

  // Marks a read whose data comes from the memory
  always @(posedge clock_i) begin
    if (reset_i) begin
      rd_mem_q <= 1'b0;
    end else begin
      rd_mem_q <= sfr_rd_i && is_cp_w;
    end
  end

  // Config registers muxed here; reserved bits read as zero
  always @(posedge clock_i) begin
    if (reset_i) begin
      rd_reg_q <= 8'h00;
    end else if (sfr_addr_i == `PWCC_ADDR_PWM_CFG) begin
      rd_reg_q <= {reload_bank_select_q, cycle_ovf_irq_enable_q, cycle_ovf_flag_q, 2'b00, cycle_length_select_q};
    end else if (sfr_addr_i == `PWCC_ADDR_CMP_CLR) begin
      rd_reg_q <= {cmp_clear_polarity_q, 4'h0, cmp_clear_enable_q};
    end else begin
      rd_reg_q <= 8'h00;
    end
  end

  // Read data from a flop; costs one extra cycle of read latency
  // Trade: a clean output timing path for a slower read
  always @(posedge clock_i) begin
    if (reset_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      sfr_rdata_o <= rd_mem_q ? mem_rdata_w : rd_reg_q;
    end
  end
endmodule // pwcc_top
`default_nettype wire

/* File: verif/pwcc_properties.sv */
// Checker for the PWM cycle and comparator clear block.
// Assumes it is bound to pwcc_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pwcc_props (
  // Single bit ports, kept on one line to stay compact
  input wire logic clock_i, reset_i, sfr_wr_i, sfr_rd_i, cmp_result_i, cycle_irq_o, cycle_ovf_pulse_o,
  // Buses
  input wire logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o,
  input wire logic [15:0] main_counter_i,
  input wire logic [2:0] pwm_mode_i, wide_pwm_select_i, cmp_clear_o, reload_valid_o,
  input wire logic [10:0] cycle_mask_o,
  input wire logic [3:0] cycle_bits_o
);
  logic en_q, cmp_q;
  logic [2:0] len_q;
  logic [7:0] clr_q;
  logic [10:0] cnt_q;
  wire wrap = ((cnt_q & cycle_mask_o) == cycle_mask_o) && ((main_counter_i[10:0] & cycle_mask_o) == 11'h000);
  wire hit = clr_q[7] ? (cmp_result_i & !cmp_q) : (!cmp_result_i & cmp_q);
  // Shadows of written settings, so each output can be tied to its cause
  always_ff @(posedge clock_i) begin
    cnt_q <= main_counter_i[10:0];
    cmp_q <= cmp_result_i;
    if (reset_i) begin
      en_q <= 1'b0;
      len_q <= 3'h0;
      clr_q <= 8'h00;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == 8'hf7) en_q <= sfr_wdata_i[6];
      if (sfr_addr_i == 8'hf7) len_q <= sfr_wdata_i[2:0];
      if (sfr_addr_i == 8'h9c) clr_q <= sfr_wdata_i;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  irq_masked_a:
    assert property (!en_q && !$past(en_q) |-> !cycle_irq_o) else $error("irq while masked");
  irq_raise_a:
    assert property (cycle_ovf_pulse_o && en_q |=> cycle_irq_o) else $error("irq missing");
  ovf_detect_a:
    assert property (wrap |-> ##1 cycle_ovf_pulse_o) else $error("overflow missed");
  flag_hold_a:
    assert property (cycle_irq_o && !$past(sfr_wr_i && sfr_addr_i == 8'hf7) |=> cycle_irq_o) else $error("flag lost");
  len_mask_a:
    assert property (cycle_bits_o inside {[8:11]} && cycle_mask_o == ((11'h001 << cycle_bits_o) - 11'h001))
      else $error("bad cycle length");
  len_code_a:
    assert property (cycle_bits_o == (($past(len_q) > 3'h3) ? 4'h8 : (4'h8 + {1'b0, $past(len_q)})))
      else $error("length code");
  reload_use_a:
    assert property ($stable(cycle_bits_o) |-> reload_valid_o ==
      ($past(pwm_mode_i & ~wide_pwm_select_i) & {3{cycle_bits_o != 4'h8}})) else $error("reload use");
  cmp_clear_a:
    assert property (cmp_clear_o == $past({3{hit}} & clr_q[2:0])) else $error("clear mismatch");
  clr_read_a:
    assert property (sfr_rd_i && sfr_addr_i == 8'h9c |-> ##2 sfr_rdata_o == ($past(clr_q, 2) & 8'h87))
      else $error("clr read");
endmodule // pwcc_props
`default_nettype wire

/* File: verif/tb_top.sv */
// Bench for the PWM cycle and comparator clear block.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock_i = 1'b0, reset_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, cmp_result_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
  logic [15:0] main_counter_i = 16'h0000;
  logic [2:0] pwm_mode_i = 3'h0, wide_pwm_select_i = 3'h0, cmp_clear_o, reload_valid_o;
  logic cycle_irq_o, cycle_ovf_pulse_o;
  logic [10:0] cycle_mask_o;
  logic [3:0] cycle_bits_o;
  int err_total = 0, checked = 0, cyc = 0;
  pwcc_top uut (.*);
  // Clock, and a ceiling far above the roughly 115 cycles needed
  always #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Register cycles: strobe for one edge, inputs move at falling edges
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock_i);
    {sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {a, d, 1'b1};
    @(negedge clock_i);
    sfr_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clock_i);
    {sfr_addr_i, sfr_rd_i} = {a, 1'b1};
    @(negedge clock_i);
    sfr_rd_i = 1'b0;
    @(negedge clock_i);
    chk("rdata", e, sfr_rdata_o);
  endtask
  task automatic t_regs;
    rd(8'hf7, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h9c, 8'hff);
    rd(8'h9c, 8'h87);
    wr(8'h9c, 8'h00);
    wr(8'hf7, 8'h18);
    rd(8'hf7, 8'h00);
    wr(8'he9, 8'h11);
    wr(8'hf7, 8'h80);
    wr(8'he9, 8'h22);
    wr(8'hee, 8'h33);
    rd(8'he9, 8'h22);
    rd(8'hee, 8'h33);
    wr(8'hf7, 8'h00);
    rd(8'he9, 8'h11);
    $display("regs ok");
  endtask
  // Every length code, with channel 1 in wide mode
  task automatic t_len;
    pwm_mode_i = 3'h7;
    wide_pwm_select_i = 3'h2;
    for (int c = 0; c < 8; c++) begin
      wr(8'hf7, c[7:0]);
      repeat (3) @(negedge clock_i);
      chk("bits", c > 3 ? 8 : 8 + c, cycle_bits_o);
      chk("mask", (16'h0001 << (c > 3 ? 8 : 8 + c)) - 16'h0001, cycle_mask_o);
      chk("reload", c == 0 || c > 3 ? 0 : 5, reload_valid_o);
    end
    $display("len ok");
  endtask
  task automatic t_ovf;
    wr(8'hf7, 8'h41);
    repeat (3) @(negedge clock_i);
    main_counter_i = 16'h01ff;
    @(negedge clock_i) main_counter_i = 16'h0200;
    @(negedge clock_i);
    chk("pulse", 1, cycle_ovf_pulse_o);
    @(negedge clock_i);
    chk("irq", 1, cycle_irq_o);
    rd(8'hf7, 8'h61);
    wr(8'hf7, 8'h01);
    main_counter_i = 16'h03ff;
    @(negedge clock_i) main_counter_i = 16'h0400;
    @(negedge clock_i);
    chk("pulse", 1, cycle_ovf_pulse_o);
    @(negedge clock_i);
    chk("irq", 0, cycle_irq_o);
    rd(8'hf7, 8'h21);
    wr(8'hf7, 8'h60);
    repeat (2) @(negedge clock_i);
    chk("irq", 1, cycle_irq_o);
    wr(8'hf7, 8'h00);
    $display("ovf ok");
  endtask
  task automatic t_clr;
    wr(8'h9c, 8'h05);
    cmp_result_i = 1'b1;
    @(negedge clock_i);
    chk("clear", 0, cmp_clear_o);
    @(negedge clock_i);
    cmp_result_i = 1'b0;
    @(negedge clock_i);
    chk("clear", 5, cmp_clear_o);
    wr(8'h9c, 8'h82);
    cmp_result_i = 1'b1;
    @(negedge clock_i);
    chk("clear", 2, cmp_clear_o);
    $display("clr ok");
  endtask
  task automatic finish_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clock_i);
    reset_i = 1'b0;
    t_regs();
    t_len();
    t_ovf();
    t_clr();
    finish_test();
  end
endmodule // tb_top
bind pwcc_top pwcc_props chk_u (.*);
`default_nettype wire
